// ==== bench/osd_channel_properties.sv ====
// port assertions for the output sync and channel divider
`timescale 1ns/1ps
`include "osd_map.svh"
module osd_channel_properties
	import osd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire osd_bus_type bus,
	input wire logic [7:0] rdata,
	input wire logic out_loop_cal_lock,
	input wire logic sync_hold_b,
	input wire logic sync_release_b,
	input wire logic clk_out_a,
	input wire osd_drive_type drive_a
);
	logic ovr, mask_a, mask_b, seen;
	// mirrors of the gate bits and a sticky copy of the loop lock, so sync rules are judged from the ports alone
	always_ff @(posedge clk) begin
		if (!resetn) begin
			{ovr, mask_b, mask_a, seen} <= 4'h0;
		end else begin
			seen <= seen | out_loop_cal_lock;
			if (bus.wr && bus.addr == `OSD_ADDR_GATE_MASK) begin
				{ovr, mask_b, mask_a} <= bus.wdata[2:0];
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence rel_s;
		sync_release_b ##1 !sync_release_b;
	endsequence
	read_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	mode_exclusive_a: assert property (!(drive_a.lvds_mode && drive_a.hstl_mode))
		else $error("two output modes at once");
	single_pad_a: assert property (drive_a.pad_p_en != drive_a.pad_n_en |-> !drive_a.lvds_mode && !drive_a.hstl_mode)
		else $error("single pad outside cmos");
	release_pulse_a: assert property (sync_release_b |-> rel_s)
		else $error("release longer than one cycle");
	release_after_a: assert property (sync_release_b |-> $past(sync_hold_b))
		else $error("release without hold");
	unarmed_quiet_a: assert property (!ovr && !seen |-> !sync_hold_b)
		else $error("sync before output loop lock");
	mask_b_free_a: assert property (mask_b && $past(mask_b, 3) |-> !sync_hold_b)
		else $error("masked channel b held");
	hold_low_a: assert property (sync_hold_b && $past(sync_hold_b) && !mask_a |-> !clk_out_a)
		else $error("clock a runs during hold");
endmodule : osd_channel_properties
bind osd_channel osd_channel_properties u_props (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
	.out_loop_cal_lock(out_loop_cal_lock), .sync_hold_b(sync_hold_b), .sync_release_b(sync_release_b),
	.clk_out_a(clk_out_a), .drive_a(drive_a));

// ==== bench/osd_channel_test.sv ====
// self-checking bench for the output sync and channel divider
`timescale 1ns/1ps
module osd_channel_test
	import osd_pkg::*;
;
	logic clk = 0, resetn = 0, pre_tick = 1, cal = 0;
	logic [3:0] ev = 0;
	osd_bus_type bus = '0;
	logic [7:0] rdata, d;
	logic [11:0] a;
	logic sync_hold_b, sync_release_b, clk_out_a;
	osd_drive_type drive_a;
	int num_errors = 0, checks = 0, n;
	logic [31:0] lfsr = 32'h0000_26c0;
	always #2.5 clk = ~clk;
	osd_channel DUT (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .pre_tick(pre_tick),
		.sync_request(ev[0]), .active_ref_sync(ev[1]), .loop_freq_lock(ev[2]), .loop_phase_lock(ev[3]),
		.out_loop_cal_lock(cal), .sync_hold_b(sync_hold_b), .sync_release_b(sync_release_b),
		.clk_out_a(clk_out_a), .drive_a(drive_a));
	function logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	function logic [7:0] rmask(input logic [11:0] r);
		return r == 12'h527 ? 8'h7e : r == 12'h528 ? 8'hff : r == 12'h529 ? 8'h03 : r == 12'h52a ? 8'h3f : 8'h07;
	endfunction : rmask
	function logic [1:0] pads(input logic [2:0] f);
		return f == 3'b000 ? 2'b00 : f == 3'b101 ? 2'b10 : f == 3'b110 ? 2'b01 : 2'b11;
	endfunction : pads
	task cmp(input logic [10:0] g, input logic [10:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	task step;
		@(posedge clk);
		#1;
	endtask : step
	task wr(input logic [11:0] r, input logic [7:0] w);
		@(posedge clk);
		bus <= '{r, w, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] r);
		@(posedge clk);
		bus <= '{r, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	// pulse one sync source and see whether channel b is held
	task fire(input int i, input logic e);
		logic s;
		s = 0;
		@(posedge clk);
		ev <= 4'h1 << i;
		repeat (3) @(posedge clk);
		ev <= 4'h0;
		repeat (12) begin
			step;
			s |= sync_hold_b;
		end
		cmp(s, e);
		n = 0;
		while (sync_hold_b !== 1'b0 && n < 200) begin
			step;
			n++;
		end
	endtask : fire
	// measure a whole high phase; pre_tick is always on, so one tick is one cycle
	task period(input logic [9:0] v);
		wr(12'h528, v[7:0]);
		wr(12'h529, {6'h00, v[9:8]});
		n = 0;
		while (clk_out_a !== 1'b0 && n < 3000) begin step; n++; end
		while (clk_out_a !== 1'b1 && n < 6000) begin step; n++; end
		n = 0;
		while (clk_out_a === 1'b1 && n < 3000) begin n++; step; end
		cmp(11'(n), 11'(v) + 11'd1);
	endtask : period
	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#400000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1;
		for (int r = 12'h525; r <= 12'h531; r++) begin
			rd(12'(r));
			cmp(d, r == 12'h527 ? 8'h10 : 8'h00);
		end
		cmp({drive_a.pad_p_en, drive_a.pad_n_en, drive_a.hstl_mode, drive_a.lvds_mode}, 4'b1110);
		for (int p = 0; p < 4; p++) begin
			wr(12'h527, 8'(8'h40 | p << 2));
			step;
			step;
			cmp({drive_a.pad_p, drive_a.pad_n}, {p[1], ~(p[1] ^ p[0])});
		end
		for (int f = 0; f < 8; f++) if (f != 3 && f != 7) begin
			wr(12'h527, 8'(f << 4));
			step;
			step;
			cmp({drive_a.pad_p_en, drive_a.pad_n_en, drive_a.lvds_mode, drive_a.hstl_mode},
				{pads(3'(f)), f == 2, f == 1});
		end
		for (int b = 0; b < 2; b++) begin
			wr(12'h527, 8'(8'h20 | b << 1));
			step;
			step;
			cmp(drive_a.boost, b[0]);
		end
		fire(0, 1'b0);
		repeat (12) begin
			lfsr = nx(lfsr);
			a = 12'h525 + 12'(lfsr[10:8] % 3'd6);
			wr(a, lfsr[7:0]);
			rd(a);
			cmp(d, lfsr[7:0] & rmask(a));
		end
		wr(12'h526, 8'h00);
		cal <= 1;
		wr(12'h525, 8'h00);
		fire(0, 1'b1);
		wr(12'h525, 8'h04);
		fire(1, 1'b1);
		fire(2, 1'b0);
		wr(12'h525, 8'h01);
		fire(2, 1'b1);
		fire(3, 1'b0);
		wr(12'h525, 8'h02);
		fire(3, 1'b1);
		fire(2, 1'b0);
		wr(12'h525, 8'h00);
		wr(12'h526, 8'h02);
		fire(0, 1'b0);
		wr(12'h526, 8'h01);
		fire(0, 1'b1);
		cmp(sync_hold_b, 1'b0);
		period(10'h000);
		period(10'h3ff);
		lfsr = nx(lfsr);
		period(lfsr[9:0]);
		@(posedge clk);
		resetn <= 0;
		cal <= 0;
		repeat (3) @(posedge clk);
		resetn <= 1;
		wr(12'h526, 8'h04);
		fire(0, 1'b1);
		report_and_stop;
	end
endmodule : osd_channel_test

// ==== inc/osd_map.svh ====
// register offsets, field positions, reset values and timing for the output sync and channel divider
`ifndef OSD_MAP_SVH
`define OSD_MAP_SVH
`define OSD_ADDR_SYNC_CFG 12'h0525
`define OSD_ADDR_GATE_MASK 12'h0526
`define OSD_ADDR_OUT_CFG 12'h0527
`define OSD_ADDR_DIV_LO 12'h0528
`define OSD_ADDR_DIV_HI 12'h0529
`define OSD_ADDR_PHASE 12'h052A
`define OSD_ADDR_STATUS 12'h052F
`define OSD_SRC_BIT 2
`define OSD_AUTO_LSB 0
`define OSD_OVR_BIT 2
`define OSD_MASKB_BIT 1
`define OSD_MASKA_BIT 0
`define OSD_FMT_LSB 4
`define OSD_POL_LSB 2
`define OSD_BOOST_BIT 1
`define OSD_RST_SYNC_CFG 8'h00
`define OSD_RST_GATE_MASK 8'h00
`define OSD_RST_OUT_CFG 8'h10
`define OSD_RST_DIV_LO 8'h00
`define OSD_RST_DIV_HI 8'h00
`define OSD_RST_PHASE 8'h00
`define OSD_HOLD_CYCLES 4
`endif

// ==== inc/osd_pkg.sv ====
// types for the output sync and channel divider
package osd_pkg;
	typedef enum logic [1:0] {
		osd_auto_off = 2'b00,
		osd_auto_freq = 2'b01,
		osd_auto_phase = 2'b10,
		osd_auto_rsvd = 2'b11
	} osd_auto_type;
	typedef enum logic [2:0] {
		osd_fmt_off = 3'b000,
		osd_fmt_hstl = 3'b001,
		osd_fmt_lvds = 3'b010,
		osd_fmt_rsv3 = 3'b011,
		osd_fmt_cmos = 3'b100,
		osd_fmt_cmos_p = 3'b101,
		osd_fmt_cmos_n = 3'b110,
		osd_fmt_rsv7 = 3'b111
	} osd_fmt_type;
	typedef enum logic [1:0] {
		osd_st_idle = 2'b00,
		osd_st_hold = 2'b01,
		osd_st_run = 2'b10
	} osd_state_type;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} osd_bus_type;
	typedef struct packed {
		logic pad_p_en;
		logic pad_n_en;
		logic pad_p;
		logic pad_n;
		logic lvds_mode;
		logic hstl_mode;
		logic boost;
	} osd_drive_type;
endpackage : osd_pkg

// ==== logic/osd_channel.sv ====
// sync control and channel A output divider of the clock distribution path
//
// Notes on behaviour
// - sync source bit picks direct request (0, default) or active reference (1).
// - auto sync field: 00 off, 01 on frequency lock, 10 on phase lock, 11 reserved.
// - override clear: sync stays disabled until output loop calibrated and locked.
// - override set: ignore output loop lock, sync config always controls sync.
// - channel A mask releases divider immediately, ignores sync, leaves drivers alone.
// - channel B mask releases channel B divider, ignores sync, leaves drivers alone.
// - channel A format: off, HSTL default, LVDS, CMOS both, P only, N only.
// - channel A polarity: 00 pos/neg, 01 pos/pos, 10 neg/pos, 11 neg/neg.
// - boost bit chooses normal or boosted LVDS drive strength.
// - 10-bit divider from two registers, divides by value plus one.
// - six-bit phase sets initial offset after sync in half input periods.
`timescale 1ns/1ps
`include "osd_map.svh"
module osd_channel
	import osd_pkg::*;
#(
	parameter int div_width = 10,
	parameter int phase_width = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire osd_bus_type bus,
	output logic [7:0] rdata,
	input wire logic pre_tick,
	input wire logic sync_request,
	input wire logic active_ref_sync,
	input wire logic loop_freq_lock,
	input wire logic loop_phase_lock,
	input wire logic out_loop_cal_lock,
	output logic sync_hold_b,
	output logic sync_release_b,
	output logic clk_out_a,
	output osd_drive_type drive_a
);
	typedef struct packed {
		logic [7:0] sync_cfg;
		logic [7:0] gate_mask;
		logic [7:0] out_cfg;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] phase;
		logic [7:0] rdata;
		logic [2:0] req_s1;
		logic [2:0] req_s2;
		logic [2:0] req_d;
		logic lock_s1;
		logic lock_s2;
		logic armed;
		osd_state_type state;
		logic [2:0] hold_cnt;
		logic [div_width:0] half_cnt;
		logic [phase_width-1:0] skip;
		logic half_phase;
		logic div_level;
		logic hold_b;
		logic release_b;
		logic sync_seen;
		osd_drive_type drive;
	} osd_state_all_type;

	osd_state_all_type r;
	osd_state_all_type next_r;

	logic [div_width-1:0] div_val;
	logic [div_width:0] half_total;
	logic [2:0] req_rise;
	logic sync_event;
	logic auto_event;
	logic sync_enabled;
	logic pol_p;
	logic pol_n;
	osd_fmt_type fmt;
	osd_auto_type auto_mode;

	assign div_val = {r.div_hi[1:0], r.div_lo};
	assign half_total = {div_val, 1'b0} + {{div_width{1'b0}}, 1'b1};
	assign fmt = osd_fmt_type'(r.out_cfg[`OSD_FMT_LSB +: 3]);
	assign auto_mode = osd_auto_type'(r.sync_cfg[`OSD_AUTO_LSB +: 2]);
	assign req_rise = r.req_s2 & ~r.req_d;
	assign pol_p = r.out_cfg[`OSD_POL_LSB + 1];
	assign pol_n = r.out_cfg[`OSD_POL_LSB];

	always_comb begin
		next_r = r;
		next_r.req_s1 = {loop_phase_lock, loop_freq_lock, r.sync_cfg[`OSD_SRC_BIT] ? active_ref_sync : sync_request};
		next_r.req_s2 = r.req_s1;
		next_r.req_d = r.req_s2;
		next_r.lock_s1 = out_loop_cal_lock;
		next_r.lock_s2 = r.lock_s1;
		// once armed, later loss of lock does not disarm: the arming is a one-time gate
		if (r.lock_s2) begin
			next_r.armed = 1'b1;
		end
		sync_enabled = r.armed | r.gate_mask[`OSD_OVR_BIT];
		auto_event = ((auto_mode == osd_auto_freq) && req_rise[1]) ||
			((auto_mode == osd_auto_phase) && req_rise[2]);
		sync_event = sync_enabled & (req_rise[0] | auto_event);
		next_r.sync_seen = sync_event;
		next_r.release_b = 1'b0;

		if (bus.wr) begin
			case (bus.addr)
				`OSD_ADDR_SYNC_CFG: begin
					next_r.sync_cfg = {5'h0, bus.wdata[2:0]};
				end
				`OSD_ADDR_GATE_MASK: begin
					next_r.gate_mask = {5'h0, bus.wdata[2:0]};
				end
				`OSD_ADDR_OUT_CFG: begin
					next_r.out_cfg = {1'b0, bus.wdata[6:1], 1'b0};
				end
				`OSD_ADDR_DIV_LO: begin
					next_r.div_lo = bus.wdata;
				end
				`OSD_ADDR_DIV_HI: begin
					next_r.div_hi = {6'h0, bus.wdata[1:0]};
				end
				`OSD_ADDR_PHASE: begin
					next_r.phase = {2'h0, bus.wdata[5:0]};
				end
				default: begin
				end
			endcase
		end
		next_r.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`OSD_ADDR_SYNC_CFG: next_r.rdata = r.sync_cfg;
				`OSD_ADDR_GATE_MASK: next_r.rdata = r.gate_mask;
				`OSD_ADDR_OUT_CFG: next_r.rdata = r.out_cfg;
				`OSD_ADDR_DIV_LO: next_r.rdata = r.div_lo;
				`OSD_ADDR_DIV_HI: next_r.rdata = r.div_hi;
				`OSD_ADDR_PHASE: next_r.rdata = r.phase;
				`OSD_ADDR_STATUS: next_r.rdata = {5'h0, r.state == osd_st_hold, r.armed, r.div_level};
				default: next_r.rdata = 8'h00;
			endcase
		end

		// channel B divider lives outside; it only sees hold and release
		if (r.gate_mask[`OSD_MASKB_BIT]) begin
			next_r.hold_b = 1'b0;
		end else if (sync_event) begin
			next_r.hold_b = 1'b1;
			if (r.gate_mask[`OSD_MASKA_BIT]) begin
				next_r.hold_cnt = 3'd0;
			end
		end else if (r.gate_mask[`OSD_MASKA_BIT] && r.hold_b && pre_tick) begin
			// channel A ignores sync while masked, so channel B times its own hold or it would stay stuck
			if (r.hold_cnt == 3'(`OSD_HOLD_CYCLES - 1)) begin
				next_r.hold_b = 1'b0;
				next_r.release_b = 1'b1;
				next_r.hold_cnt = 3'd0;
			end else begin
				next_r.hold_cnt = r.hold_cnt + 3'd1;
			end
		end

		case (r.state)
			osd_st_idle: begin
				if (r.gate_mask[`OSD_MASKA_BIT]) begin
					next_r.state = osd_st_run;
				end else if (sync_event) begin
					next_r.state = osd_st_hold;
					next_r.hold_cnt = 3'd0;
				end
			end
			osd_st_hold: begin
				next_r.div_level = 1'b0;
				if (r.gate_mask[`OSD_MASKA_BIT]) begin
					next_r.state = osd_st_run;
					next_r.half_cnt = '0;
				end else if (pre_tick) begin
					// wait a few input edges so both channels see the same release edge
					if (r.hold_cnt == 3'(`OSD_HOLD_CYCLES - 1)) begin
						next_r.state = osd_st_run;
						next_r.half_cnt = '0;
						next_r.skip = r.phase[phase_width-1:1];
						next_r.half_phase = r.phase[0];
						next_r.hold_b = 1'b0;
						next_r.release_b = r.hold_b;
					end else begin
						next_r.hold_cnt = r.hold_cnt + 3'd1;
					end
				end
			end
			osd_st_run: begin
				if (sync_event && !r.gate_mask[`OSD_MASKA_BIT]) begin
					next_r.state = osd_st_hold;
					next_r.hold_cnt = 3'd0;
				end else if (pre_tick) begin
					if (r.skip != '0) begin
						next_r.skip = r.skip - 1'b1;
					end else if (div_val == '0) begin
						next_r.div_level = ~r.div_level;
					end else if (r.half_cnt + {{div_width{1'b0}}, r.half_phase} + 1'b1 >= half_total) begin
						// both halves last value plus one ticks for every ratio, so high and low are equal except the first low phase after a sync, which also spans hold and skip
						next_r.div_level = ~r.div_level;
						next_r.half_cnt = '0;
						next_r.half_phase = 1'b0;
					end else begin
						next_r.half_cnt = r.half_cnt + 2'd2;
					end
				end
			end
			default: begin
				next_r.state = osd_st_idle;
			end
		endcase

		// mask never turns drivers on; only format does
		next_r.drive.pad_p_en = (fmt == osd_fmt_hstl) || (fmt == osd_fmt_lvds) ||
			(fmt == osd_fmt_cmos) || (fmt == osd_fmt_cmos_p);
		next_r.drive.pad_n_en = (fmt == osd_fmt_hstl) || (fmt == osd_fmt_lvds) ||
			(fmt == osd_fmt_cmos) || (fmt == osd_fmt_cmos_n);
		next_r.drive.lvds_mode = (fmt == osd_fmt_lvds);
		next_r.drive.hstl_mode = (fmt == osd_fmt_hstl);
		next_r.drive.boost = r.out_cfg[`OSD_BOOST_BIT];
		next_r.drive.pad_p = next_r.drive.pad_p_en & (next_r.div_level ^ pol_p);
		next_r.drive.pad_n = next_r.drive.pad_n_en & (next_r.div_level ^ ~(pol_p ^ pol_n));

		if (!resetn) begin
			next_r = '0;
			next_r.sync_cfg = `OSD_RST_SYNC_CFG;
			next_r.gate_mask = `OSD_RST_GATE_MASK;
			next_r.out_cfg = `OSD_RST_OUT_CFG;
			next_r.div_lo = `OSD_RST_DIV_LO;
			next_r.div_hi = `OSD_RST_DIV_HI;
			next_r.phase = `OSD_RST_PHASE;
			next_r.state = osd_st_idle;
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	assign rdata = r.rdata;
	assign sync_hold_b = r.hold_b;
	assign sync_release_b = r.release_b;
	assign clk_out_a = r.div_level;
	assign drive_a = r.drive;
endmodule : osd_channel
